//--- src/debug_entry_pkg.sv
// Shared constants and types for the debug entry controller.
// Assumes a single core clock domain; all values are sized for their users.

package debug_entry_pkg;

  // ===========================================================================
  // Controller states and entry causes
  // ===========================================================================
  typedef enum logic [2:0] {
    ST_RUN,
    ST_BKPT_EXEC,
    ST_WPT_DRAIN,
    ST_WPT_DELAY,
    ST_EXC_ENTRY,
    ST_REQ_DRAIN,
    ST_DEBUG
  } dbg_state_e;

  typedef enum logic [1:0] {
    CAUSE_NONE,
    CAUSE_BKPT,
    CAUSE_WPT,
    CAUSE_REQ
  } dbg_cause_e;

  // ===========================================================================
  // Program counter bias after watchpoint entry
  // ===========================================================================
  localparam int INSTR_BYTES   = 4;
  localparam int WPT_PC_AHEAD  = 5;
  localparam int WPT_PC_OFFSET = INSTR_BYTES * WPT_PC_AHEAD;

  // ===========================================================================
  // Scan chain numbering
  // ===========================================================================
  localparam int         SCAN_SEL_W          = 5;
  localparam int         SCAN_CHAIN_COUNT    = 32;
  localparam int         SCAN_RESERVED_COUNT = 16;
  localparam logic [4:0] SCAN_RESET_CHAIN    = 5'h03;
  localparam logic [4:0] SCAN_BSCAN_CHAIN    = 5'h03;
  localparam logic [4:0] SCAN_LAST_LOW_CHAIN = 5'h04;
  localparam logic [4:0] SCAN_TOP_CHAIN      = 5'h0F;

  // ===========================================================================
  // Memory interface levels for an internal cycle, and synchroniser depth
  // ===========================================================================
  localparam logic IDLE_MREQ_N  = 1'b1;
  localparam logic IDLE_SEQ     = 1'b0;
  localparam int   SYNC_STAGES  = 2;

endpackage

//--- src/debug_sync.sv
// Multi-bit level synchroniser, one independent chain per bit.
// Assumes each input bit is a slow level; no bus coherency is implied.

`timescale 1ns/1ns
`default_nettype none

module debug_sync #(
  parameter int WIDTH  = 2,
  parameter int STAGES = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  // ===========================================================================
  // Elaboration checks
  // ===========================================================================
  if (STAGES < 2) begin : g_bad_stages
    $error("debug_sync needs at least two stages");
  end

  // Stage 0 feeds only stage 1; nothing else may look at it
  logic [STAGES-1:0][WIDTH-1:0] stage;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage <= '0;
    end else begin
      stage[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign q = stage[STAGES-1];

endmodule

`default_nettype wire

//--- src/debug_entry_control.sv
// Debug entry controller: arbitrates debug entry against aborts and interrupts,
// drives debug acknowledge, idles the memory ports and holds the scan chain select.
// Assumes the core pipeline supplies boundary and completion strobes on CORE_CLK.
// How it works
// - Outside and internal breakpoint sources are ORed before reaching control.
// - Breakpointed instruction enters execute with its state change suppressed.
// - Breakpoint entry sequence overlaps execute of the breakpointed instruction.
// - Prefetch abort on a breakpointed instruction wins; breakpoint is dropped.
// - Breakpoint beats the software interrupt or undefined exception.
// - Interrupt at boundary wins over breakpoint; instruction is discarded, refetched.
// - Debug state disables interrupts; status register mask bits untouched.
// - After watchpoint the next instruction completes; single-cycle ones add a cycle.
// - Instruction after the completing one is suppressed during watchpoint entry.
// - Watchpoint entry leaves PC twenty bytes beyond the next instruction.
// - Aborting watchpointed access takes abort entry first, then debug.
// - Pending interrupt at watchpoint takes interrupt entry first, then debug.
// - Debug requests are synchronised and beat any pending interrupt.
// - After a request issue stalls; debug follows once the pipe drains.
// - In debug both memory ports show internal cycles; aborts, interrupts ignored.
// - Debug acknowledge is high exactly while in debug state.
// - Up to 32 chains selectable, 0 to 15 reserved; select output reports chain.
// - Chains 0-4 and 15 are internal; external boundary chain signals provided.

`timescale 1ns/1ns
`default_nettype none

module debug_entry_control #(
  parameter int PC_W = 32
) (
  input  wire logic            CORE_CLK,
  input  wire logic            NRST,
  input  wire logic            EXT_BREAKPOINT_IN,
  input  wire logic            ICE_BREAKPOINT_IN,
  input  wire logic            DECODE_VALID,
  input  wire logic            DECODE_PABORT,
  input  wire logic            DECODE_SWI_UNDEF,
  input  wire logic            EXEC_ADVANCE,
  input  wire logic            IRQ_PENDING,
  input  wire logic            FIQ_PENDING,
  input  wire logic            EXT_WATCHPOINT_IN,
  input  wire logic            ICE_WATCHPOINT_IN,
  input  wire logic            DATA_ABORT_IN,
  input  wire logic            NEXT_SINGLE_CYCLE_DP,
  input  wire logic            NEXT_COMPLETE,
  input  wire logic            EXC_ENTRY_DONE,
  input  wire logic            EXT_DEBUG_REQUEST,
  input  wire logic            ICE_DEBUG_REQUEST,
  input  wire logic            PIPE_DRAINED,
  input  wire logic            RESTART,
  input  wire logic [PC_W-1:0] NEXT_PC,
  input  wire logic            CORE_IMREQ_N,
  input  wire logic            CORE_INSTR_SEQUENTIAL,
  input  wire logic            CORE_DMREQ_N,
  input  wire logic            CORE_DATA_SEQUENTIAL,
  input  wire logic            SCAN_UPDATE,
  input  wire logic [4:0]      SCAN_CHAIN_SEL_IN,
  output var  logic            DEBUG_ACK_OUT,
  output var  logic [1:0]      DEBUG_CAUSE,
  output var  logic            EXEC_SUPPRESS,
  output var  logic            ISSUE_STALL,
  output var  logic            INT_DISABLE,
  output var  logic            TAKE_PREFETCH_ABORT,
  output var  logic            TAKE_DATA_ABORT,
  output var  logic            TAKE_INTERRUPT,
  output var  logic            DISCARD_INSTR,
  output var  logic [PC_W-1:0] DEBUG_PC,
  output var  logic            INSTR_MEM_REQUEST_N,
  output var  logic            INSTR_SEQUENTIAL,
  output var  logic            DATA_MEM_REQUEST_N,
  output var  logic            DATA_SEQUENTIAL,
  output var  logic [4:0]      SCAN_CHAIN_SELECT_OUT,
  output var  logic            INTERNAL_CHAIN_SELECT,
  output var  logic            EXT_BSCAN_SELECT,
  output var  logic            EXTENSION_CHAIN_SELECT
);

  // ===========================================================================
  // Elaboration checks
  // ===========================================================================
  if (PC_W < 8) begin : g_bad_pc_w
    $error("debug_entry_control needs PC_W of at least 8");
  end

  // True for the chain numbers that exist inside the device
  function automatic logic chain_is_internal(input logic [4:0] num);
    chain_is_internal = (num <= debug_entry_pkg::SCAN_LAST_LOW_CHAIN) ||
                        (num == debug_entry_pkg::SCAN_TOP_CHAIN);
  endfunction

  // ===========================================================================
  // Request synchronisation and event decode
  // ===========================================================================
  logic [1:0] dbg_req_sync;
  logic       dbg_req;
  logic       bkpt;
  logic       wpt_hit;
  logic       int_pending;
  logic       boundary;
  // Both request sources go through the same two-flop synchroniser, one chain each
  debug_sync #(.WIDTH(2), .STAGES(debug_entry_pkg::SYNC_STAGES)) u_req_sync (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .d     ({ICE_DEBUG_REQUEST, EXT_DEBUG_REQUEST}),
    .q     (dbg_req_sync)
  );
  assign dbg_req     = |dbg_req_sync;
  assign bkpt        = EXT_BREAKPOINT_IN | ICE_BREAKPOINT_IN;
  assign wpt_hit     = EXT_WATCHPOINT_IN | ICE_WATCHPOINT_IN;
  assign int_pending = IRQ_PENDING | FIQ_PENDING;
  assign boundary    = DECODE_VALID & EXEC_ADVANCE;

  // ===========================================================================
  // Entry arbitration
  // ===========================================================================
  debug_entry_pkg::dbg_state_e state;
  debug_entry_pkg::dbg_state_e next_state;
  debug_entry_pkg::dbg_cause_e cause;
  debug_entry_pkg::dbg_cause_e next_cause;
  logic next_take_pabort;
  logic next_take_dabort;
  logic next_take_int;
  logic next_discard;
  logic next_suppress;
  // Exceptions are only granted from RUN, so aborts and interrupts are
  // ignored while entering, waiting in or sitting in debug state
  always_comb begin
    next_state       = state;
    next_cause       = cause;
    next_take_pabort = 1'b0;
    next_take_dabort = 1'b0;
    next_take_int    = 1'b0;
    next_discard     = 1'b0;
    next_suppress    = 1'b0;
    case (state)
      debug_entry_pkg::ST_RUN: begin
        if (dbg_req) begin
          next_state = debug_entry_pkg::ST_REQ_DRAIN;
          next_cause = debug_entry_pkg::CAUSE_REQ;
        end else if (wpt_hit) begin
          next_cause = debug_entry_pkg::CAUSE_WPT;
          if (DATA_ABORT_IN) begin
            next_take_dabort = 1'b1;
            next_state       = debug_entry_pkg::ST_EXC_ENTRY;
          end else if (int_pending) begin
            next_take_int = 1'b1;
            next_state    = debug_entry_pkg::ST_EXC_ENTRY;
          end else begin
            next_state = debug_entry_pkg::ST_WPT_DRAIN;
          end
        end else if (boundary) begin
          if (DECODE_PABORT) begin
            next_take_pabort = 1'b1;
          end else if (int_pending) begin
            next_take_int = 1'b1;
            next_discard  = bkpt;
          end else if (bkpt) begin
            // SWI and undefined are simply suppressed like any other opcode
            next_state    = debug_entry_pkg::ST_BKPT_EXEC;
            next_cause    = debug_entry_pkg::CAUSE_BKPT;
            next_suppress = 1'b1;
          end
        end
      end
      debug_entry_pkg::ST_BKPT_EXEC: next_state = debug_entry_pkg::ST_DEBUG;
      debug_entry_pkg::ST_WPT_DRAIN: begin
        if (NEXT_COMPLETE) begin
          next_suppress = 1'b1;
          next_state    = NEXT_SINGLE_CYCLE_DP ? debug_entry_pkg::ST_WPT_DELAY
                                               : debug_entry_pkg::ST_DEBUG;
        end
      end
      debug_entry_pkg::ST_WPT_DELAY: next_state = debug_entry_pkg::ST_DEBUG;
      debug_entry_pkg::ST_EXC_ENTRY: begin
        if (EXC_ENTRY_DONE) next_state = debug_entry_pkg::ST_DEBUG;
      end
      debug_entry_pkg::ST_REQ_DRAIN: begin
        if (PIPE_DRAINED) next_state = debug_entry_pkg::ST_DEBUG;
      end
      debug_entry_pkg::ST_DEBUG: begin
        if (RESTART) begin
          next_state = debug_entry_pkg::ST_RUN;
          next_cause = debug_entry_pkg::CAUSE_NONE;
        end
      end
      default: next_state = debug_entry_pkg::ST_RUN;
    endcase
  end
  // State and cause
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      state <= debug_entry_pkg::ST_RUN;
      cause <= debug_entry_pkg::CAUSE_NONE;
    end else begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  // ===========================================================================
  // Pipeline control outputs
  // ===========================================================================
  // Registered from next_state so they line up with the state register
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      DEBUG_ACK_OUT       <= 1'b0;
      DEBUG_CAUSE         <= 2'h0;
      EXEC_SUPPRESS       <= 1'b0;
      ISSUE_STALL         <= 1'b0;
      INT_DISABLE         <= 1'b0;
      TAKE_PREFETCH_ABORT <= 1'b0;
      TAKE_DATA_ABORT     <= 1'b0;
      TAKE_INTERRUPT      <= 1'b0;
      DISCARD_INSTR       <= 1'b0;
    end else begin
      DEBUG_ACK_OUT       <= (next_state == debug_entry_pkg::ST_DEBUG);
      DEBUG_CAUSE         <= next_cause;
      EXEC_SUPPRESS       <= next_suppress;
      ISSUE_STALL         <= (next_state == debug_entry_pkg::ST_REQ_DRAIN) ||
                             (next_state == debug_entry_pkg::ST_DEBUG);
      // Only the handling is gated; the mask bits live elsewhere, untouched
      INT_DISABLE         <= (next_state == debug_entry_pkg::ST_DEBUG);
      TAKE_PREFETCH_ABORT <= next_take_pabort;
      TAKE_DATA_ABORT     <= next_take_dabort;
      TAKE_INTERRUPT      <= next_take_int;
      DISCARD_INSTR       <= next_discard;
    end
  end

  // PC bias is captured only on the cycle that completes a watchpoint entry
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      DEBUG_PC <= '0;
    end else if (next_state == debug_entry_pkg::ST_DEBUG &&
                 state != debug_entry_pkg::ST_DEBUG &&
                 next_cause == debug_entry_pkg::CAUSE_WPT) begin
      DEBUG_PC <= NEXT_PC + PC_W'(debug_entry_pkg::WPT_PC_OFFSET);
    end
  end

  // ===========================================================================
  // Memory interface cycle type
  // ===========================================================================
  // Costs one cycle of latency on the core's own request, but keeps every
  // output a flop and lets the idle forcing change on the ack edge
  always_ff @(posedge CORE_CLK) begin
    if (!NRST || next_state == debug_entry_pkg::ST_DEBUG) begin
      INSTR_MEM_REQUEST_N <= debug_entry_pkg::IDLE_MREQ_N;
      INSTR_SEQUENTIAL    <= debug_entry_pkg::IDLE_SEQ;
      DATA_MEM_REQUEST_N  <= debug_entry_pkg::IDLE_MREQ_N;
      DATA_SEQUENTIAL     <= debug_entry_pkg::IDLE_SEQ;
    end else begin
      INSTR_MEM_REQUEST_N <= CORE_IMREQ_N;
      INSTR_SEQUENTIAL    <= CORE_INSTR_SEQUENTIAL;
      DATA_MEM_REQUEST_N  <= CORE_DMREQ_N;
      DATA_SEQUENTIAL     <= CORE_DATA_SEQUENTIAL;
    end
  end

  // ===========================================================================
  // Scan chain selection
  // ===========================================================================
  // Any of the 32 numbers is accepted; the flags tell which space it is in
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      SCAN_CHAIN_SELECT_OUT  <= debug_entry_pkg::SCAN_RESET_CHAIN;
      INTERNAL_CHAIN_SELECT  <= chain_is_internal(debug_entry_pkg::SCAN_RESET_CHAIN);
      EXT_BSCAN_SELECT       <= 1'b1;
      EXTENSION_CHAIN_SELECT <= 1'b0;
    end else if (SCAN_UPDATE) begin
      SCAN_CHAIN_SELECT_OUT  <= SCAN_CHAIN_SEL_IN;
      INTERNAL_CHAIN_SELECT  <= chain_is_internal(SCAN_CHAIN_SEL_IN);
      EXT_BSCAN_SELECT       <= (SCAN_CHAIN_SEL_IN == debug_entry_pkg::SCAN_BSCAN_CHAIN);
      EXTENSION_CHAIN_SELECT <= (32'(SCAN_CHAIN_SEL_IN) >=
                                 debug_entry_pkg::SCAN_RESERVED_COUNT);
    end
  end

  // ===========================================================================
  // Assertions
  // ===========================================================================
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic quiet_run;
  assign quiet_run = (state == debug_entry_pkg::ST_RUN) && !dbg_req && !wpt_hit;
  AST_BKPT_OR: assert property (
    quiet_run && boundary && !DECODE_PABORT && !int_pending && bkpt
    |=> state == debug_entry_pkg::ST_BKPT_EXEC && EXEC_SUPPRESS)
    else $error("breakpoint source did not start entry");
  AST_BKPT_SUPPRESS: assert property (
    state == debug_entry_pkg::ST_BKPT_EXEC |-> EXEC_SUPPRESS && !DEBUG_ACK_OUT)
    else $error("breakpointed instruction not suppressed");
  AST_BKPT_ENTRY: assert property (
    state == debug_entry_pkg::ST_BKPT_EXEC |=> DEBUG_ACK_OUT && DEBUG_CAUSE == 2'h1)
    else $error("breakpoint entry not one cycle after execute");
  AST_PABORT_WINS: assert property (
    quiet_run && boundary && DECODE_PABORT
    |=> TAKE_PREFETCH_ABORT && state == debug_entry_pkg::ST_RUN)
    else $error("prefetch abort did not win over breakpoint");
  AST_SWI_LOSES: assert property (
    quiet_run && boundary && !DECODE_PABORT && !int_pending && bkpt && DECODE_SWI_UNDEF
    |=> !TAKE_INTERRUPT ##1 DEBUG_ACK_OUT)
    else $error("breakpoint did not beat swi or undefined");
  AST_INT_WINS: assert property (
    quiet_run && boundary && !DECODE_PABORT && int_pending && bkpt
    |=> TAKE_INTERRUPT && DISCARD_INSTR && !EXEC_SUPPRESS)
    else $error("interrupt did not discard breakpointed instruction");
  AST_INT_OFF: assert property (
    DEBUG_ACK_OUT |-> INT_DISABLE && !TAKE_INTERRUPT)
    else $error("interrupts live in debug state");
  AST_WPT_DELAY: assert property (
    state == debug_entry_pkg::ST_WPT_DRAIN && NEXT_COMPLETE && NEXT_SINGLE_CYCLE_DP
    |=> !DEBUG_ACK_OUT && EXEC_SUPPRESS ##1 DEBUG_ACK_OUT)
    else $error("single-cycle delay after watchpoint wrong");
  AST_WPT_PC: assert property (
    $rose(DEBUG_ACK_OUT) && DEBUG_CAUSE == 2'h2 && $past(state) != debug_entry_pkg::ST_EXC_ENTRY
    |-> DEBUG_PC == $past(NEXT_PC) + PC_W'(debug_entry_pkg::WPT_PC_OFFSET))
    else $error("watchpoint pc bias wrong");
  AST_WPT_ABORT: assert property (
    state == debug_entry_pkg::ST_RUN && !dbg_req && wpt_hit && DATA_ABORT_IN
    |=> TAKE_DATA_ABORT && !DEBUG_ACK_OUT && state == debug_entry_pkg::ST_EXC_ENTRY)
    else $error("abort entry not before watchpoint debug");
  AST_WPT_INT: assert property (
    state == debug_entry_pkg::ST_RUN && !dbg_req && wpt_hit && !DATA_ABORT_IN && int_pending
    |=> TAKE_INTERRUPT && state == debug_entry_pkg::ST_EXC_ENTRY)
    else $error("interrupt entry not before watchpoint debug");
  AST_REQ_PRIO: assert property (
    state == debug_entry_pkg::ST_RUN && dbg_req
    |=> !TAKE_INTERRUPT && ISSUE_STALL && state == debug_entry_pkg::ST_REQ_DRAIN)
    else $error("debug request lost to interrupt");
  AST_REQ_DRAIN: assert property (
    state == debug_entry_pkg::ST_REQ_DRAIN && !PIPE_DRAINED |=> ISSUE_STALL && !DEBUG_ACK_OUT)
    else $error("entered debug before pipe drained");
  AST_IDLE_MEM: assert property (
    DEBUG_ACK_OUT |-> INSTR_MEM_REQUEST_N && DATA_MEM_REQUEST_N &&
                      !INSTR_SEQUENTIAL && !DATA_SEQUENTIAL && !TAKE_DATA_ABORT)
    else $error("memory ports not idle in debug");
  AST_ACK_STATE: assert property (
    DEBUG_ACK_OUT == (state == debug_entry_pkg::ST_DEBUG))
    else $error("debug acknowledge disagrees with state");
  AST_SCAN_SEL: assert property (
    SCAN_UPDATE |=> SCAN_CHAIN_SELECT_OUT == $past(SCAN_CHAIN_SEL_IN) &&
                    EXTENSION_CHAIN_SELECT == SCAN_CHAIN_SELECT_OUT[4])
    else $error("scan chain select not reported");
  AST_SCAN_MAP: assert property (
    INTERNAL_CHAIN_SELECT == chain_is_internal(SCAN_CHAIN_SELECT_OUT) &&
    EXT_BSCAN_SELECT == (SCAN_CHAIN_SELECT_OUT == debug_entry_pkg::SCAN_BSCAN_CHAIN))
    else $error("scan chain map flags wrong");
  AST_REQ_SYNC: assert property (
    $past(NRST, 2) |-> dbg_req_sync[0] == $past(EXT_DEBUG_REQUEST, 2))
    else $error("debug request not two flops deep");
  COV_BKPT: cover property (state == debug_entry_pkg::ST_BKPT_EXEC ##1 DEBUG_ACK_OUT);
  COV_WPT_DELAY: cover property (state == debug_entry_pkg::ST_WPT_DELAY ##1 DEBUG_ACK_OUT);
  COV_REQ: cover property (state == debug_entry_pkg::ST_REQ_DRAIN ##1 DEBUG_ACK_OUT);
  COV_EXIT: cover property (DEBUG_ACK_OUT && RESTART ##1 !DEBUG_ACK_OUT);

endmodule

`default_nettype wire

//--- test/pipe_drain_model.sv
// Far-side model: execute pipeline that drains once issue stalls.
// Assumes one core clock; the stall comes from the controller.
`timescale 1ns/1ns
`default_nettype none
module pipe_drain_model (
  input  wire logic clk,
  input  wire logic stall,
  input  wire logic slow,
  output var  logic drained
);
  logic [1:0] cnt;
  // ====================
  // Drain timer: prompt after one cycle, slow after three
  always_ff @(posedge clk) begin
    if (!stall) begin
      cnt     <= 2'h0;
      drained <= 1'h0;
    end else begin
      cnt     <= cnt + {1'h0, cnt != 2'h3}; // Saturates so drained holds while stalled
      drained <= (cnt >= (slow ? 2'h2 : 2'h0));
    end
  end
endmodule
`default_nettype wire

//--- test/debug_entry_control_tb.sv
// Self-checking bench for the debug entry controller, one task per scenario.
// Assumes pipe_drain_model answers the drain after a stall.
`timescale 1ns/1ns
`default_nettype none
module debug_entry_control_tb;
  // ====================
  // Signals, named as the controller's ports
  logic CORE_CLK = 1'h0, NRST = 1'h0, SLOW = 1'h0, RESTART = 1'h0;
  logic EXT_DEBUG_REQUEST = 1'h0, ICE_DEBUG_REQUEST = 1'h0, PIPE_DRAINED;
  logic EXT_BREAKPOINT_IN, ICE_BREAKPOINT_IN, DECODE_VALID, DECODE_PABORT, DECODE_SWI_UNDEF;
  logic EXEC_ADVANCE, IRQ_PENDING, FIQ_PENDING, EXT_WATCHPOINT_IN, ICE_WATCHPOINT_IN;
  logic DATA_ABORT_IN, NEXT_SINGLE_CYCLE_DP, NEXT_COMPLETE, EXC_ENTRY_DONE, SCAN_UPDATE;
  logic CORE_IMREQ_N, CORE_INSTR_SEQUENTIAL, CORE_DMREQ_N, CORE_DATA_SEQUENTIAL, DEBUG_ACK_OUT, EXEC_SUPPRESS;
  logic ISSUE_STALL, INT_DISABLE, TAKE_PREFETCH_ABORT, TAKE_DATA_ABORT, TAKE_INTERRUPT;
  logic DISCARD_INSTR, INSTR_MEM_REQUEST_N, INSTR_SEQUENTIAL, DATA_MEM_REQUEST_N;
  logic DATA_SEQUENTIAL, INTERNAL_CHAIN_SELECT, EXT_BSCAN_SELECT, EXTENSION_CHAIN_SELECT;
  logic [1:0]  DEBUG_CAUSE;
  logic [31:0] NEXT_PC, DEBUG_PC;
  logic [4:0]  SCAN_CHAIN_SEL_IN, SCAN_CHAIN_SELECT_OUT;
  logic [4:0]  chains [6] = '{5'h00, 5'h03, 5'h05, 5'h0F, 5'h10, 5'h1F};
  int          errors = 0, checks = 0;
  // Grouped views keep each comparison to one line
  wire logic [6:0] dbg_view = {DEBUG_ACK_OUT, INT_DISABLE, ISSUE_STALL, INSTR_MEM_REQUEST_N,
    INSTR_SEQUENTIAL, DATA_MEM_REQUEST_N, DATA_SEQUENTIAL};
  wire logic [7:0] scan_view = {SCAN_CHAIN_SELECT_OUT, INTERNAL_CHAIN_SELECT, EXT_BSCAN_SELECT,
    EXTENSION_CHAIN_SELECT};
  debug_entry_control debug_entry_control_inst (.*);
  pipe_drain_model pipe_drain_model_inst (.clk(CORE_CLK), .stall(ISSUE_STALL), .slow(SLOW),
    .drained(PIPE_DRAINED));
  // Clock at 125 MHz
  always #4 CORE_CLK = ~CORE_CLK;
  // ====================
  // Shared helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Event inputs back to quiet; requests and restart are driven apart
  task clr;
    {DECODE_VALID, EXEC_ADVANCE, EXT_BREAKPOINT_IN, ICE_BREAKPOINT_IN, DECODE_PABORT} <= 5'h00;
    {DECODE_SWI_UNDEF, IRQ_PENDING, FIQ_PENDING, EXT_WATCHPOINT_IN, ICE_WATCHPOINT_IN} <= 5'h00;
    {DATA_ABORT_IN, NEXT_COMPLETE, NEXT_SINGLE_CYCLE_DP, EXC_ENTRY_DONE, SCAN_UPDATE} <= 5'h00;
  endtask
  task leave;
    @(posedge CORE_CLK);
    clr;
    RESTART <= 1'h1;
    @(posedge CORE_CLK);
    RESTART <= 1'h0;
    #1 chk({dbg_view, DEBUG_CAUSE}, {7'h05, 2'h0});
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ====================
  // Scenarios
  // Breakpointed boundary, optionally with abort, interrupt or SWI
  task automatic boundary(input logic pab, input logic irq, input logic swi, input logic ice);
    logic dbg;
    dbg = !pab && !irq;
    @(posedge CORE_CLK);
    {DECODE_VALID, EXEC_ADVANCE, DECODE_PABORT, DECODE_SWI_UNDEF} <= {2'h3, pab, swi};
    {EXT_BREAKPOINT_IN, ICE_BREAKPOINT_IN, IRQ_PENDING} <= {!ice, ice, irq};
    FIQ_PENDING <= irq & pab;
    @(posedge CORE_CLK);
    clr;
    #1 chk({TAKE_PREFETCH_ABORT, TAKE_INTERRUPT}, {pab, irq & !pab});
    chk(DISCARD_INSTR, irq & !pab);
    if (dbg) chk(EXEC_SUPPRESS, 1'h1);
    @(posedge CORE_CLK) #1 chk(DEBUG_ACK_OUT, dbg);
    if (dbg) begin
      chk({dbg_view, DEBUG_CAUSE}, {7'h7A, 2'h1});
      @(posedge CORE_CLK);
      {DECODE_VALID, EXEC_ADVANCE, IRQ_PENDING, DATA_ABORT_IN} <= 4'hF;
      @(posedge CORE_CLK) #1 chk({TAKE_INTERRUPT, TAKE_DATA_ABORT}, 2'h0);
      leave;
    end
  endtask
  // Watchpoint, drained with or without a single-cycle op, or aborting
  task automatic wpt(input logic dp, input logic ab);
    @(posedge CORE_CLK);
    {EXT_WATCHPOINT_IN, ICE_WATCHPOINT_IN, DATA_ABORT_IN} <= {!ab, ab, ab};
    NEXT_PC <= 32'h0000_1000 + {dp, ab, 4'h0};
    @(posedge CORE_CLK);
    clr;
    #1 chk({TAKE_DATA_ABORT, DEBUG_CAUSE}, {ab, 2'h2});
    @(posedge CORE_CLK);
    {NEXT_COMPLETE, NEXT_SINGLE_CYCLE_DP, EXC_ENTRY_DONE} <= {!ab, dp, ab};
    @(posedge CORE_CLK);
    clr;
    #1 chk(DEBUG_ACK_OUT, !dp);
    if (!ab) chk(EXEC_SUPPRESS, 1'h1);
    if (dp) @(posedge CORE_CLK) #1 chk(DEBUG_ACK_OUT, 1'h1);
    chk(DEBUG_PC, 32'h0000_1014 + {dp, ab, 4'h0});
    leave;
  endtask
  // Debug request racing a boundary with an interrupt pending
  task automatic req(input logic ice, input logic slow);
    @(posedge CORE_CLK);
    {EXT_DEBUG_REQUEST, ICE_DEBUG_REQUEST, SLOW} <= {!ice, ice, slow};
    repeat (2) @(posedge CORE_CLK);
    {DECODE_VALID, EXEC_ADVANCE, IRQ_PENDING} <= 3'h7;
    @(posedge CORE_CLK);
    clr;
    #1 chk({TAKE_INTERRUPT, DEBUG_CAUSE, dbg_view}, {1'h0, 2'h3, 7'h15});
    for (int i = 0; i < 8 && DEBUG_ACK_OUT !== 1'h1; i++) @(posedge CORE_CLK) #1;
    chk(dbg_view, 7'h7A);
    @(posedge CORE_CLK);
    {EXT_DEBUG_REQUEST, ICE_DEBUG_REQUEST} <= 2'h0;
    repeat (2) @(posedge CORE_CLK);
    leave;
  endtask
  // Chain select update and its decode
  task automatic scan(input logic [4:0] ch);
    @(posedge CORE_CLK);
    {SCAN_UPDATE, SCAN_CHAIN_SEL_IN} <= {1'h1, ch};
    @(posedge CORE_CLK);
    clr;
    #1 chk(scan_view, {ch, ch <= 5'h04 || ch == 5'h0F, ch == 5'h03, ch >= 5'h10});
  endtask
  // ====================
  // Main sequence; reset is released after six cycles and stays high
  initial begin
    clr;
    {NEXT_PC, SCAN_CHAIN_SEL_IN} <= {32'h0000_1000, 5'h00};
    {CORE_IMREQ_N, CORE_INSTR_SEQUENTIAL, CORE_DMREQ_N, CORE_DATA_SEQUENTIAL} <= 4'h5;
    repeat (6) @(posedge CORE_CLK);
    NRST <= 1'h1;
    #1 chk({dbg_view, scan_view}, {7'h0A, 8'h1E});
    boundary(1'h0, 1'h0, 1'h0, 1'h0);
    boundary(1'h0, 1'h0, 1'h1, 1'h1);
    boundary(1'h1, 1'h1, 1'h0, 1'h0);
    boundary(1'h0, 1'h1, 1'h0, 1'h0);
    wpt(1'h1, 1'h0);
    wpt(1'h0, 1'h0);
    wpt(1'h0, 1'h1);
    req(1'h0, 1'h0);
    req(1'h1, 1'h1);
    foreach (chains[i]) scan(chains[i]);
    test_done;
  end
  // Watchdog well beyond the fewer than a hundred cycles the scenarios need
  initial begin
    repeat (3000) @(posedge CORE_CLK);
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
